// [rtl/aed_core.sv]
`timescale 1ns/1ps

module aed_core
  import aed_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  aed_state_t  state;
  aed_state_t  next_state;
  aed_ahb_t    dph;
  logic [17:0] instr;
  logic [17:0] ac;
  logic [17:0] mq;
  logic [17:0] opnd;
  logic [17:0] ac_entry;
  logic [5:0]  sc;
  logic [5:0]  event_time;
  logic        link;
  logic        sign_flop;
  logic        prod_neg;
  logic        e_first;
  logic [17:0] next_instr;
  logic [17:0] next_ac;
  logic [17:0] next_mq;
  logic [17:0] next_opnd;
  logic [17:0] next_entry;
  logic [5:0]  next_sc;
  logic [5:0]  next_ev;
  logic        next_link;
  logic        next_sign;
  logic        next_pneg;
  logic        next_efirst;

  // bit n of an instruction word, msb-first numbering
  function automatic logic ib(input logic [17:0] w, input int n);
    ib = w[5'(17 - n)];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire logic        busy     = (state == AED_RUN);
  wire logic [2:0]  opc      = instr[8:6];
  wire logic        is_setup = (opc == AED_OP_SETUP);
  wire logic        is_mul   = (opc == AED_OP_MUL);
  wire logic        is_div   = (opc == AED_OP_DIV);
  wire logic        is_norm  = (opc == AED_OP_NORM);
  wire logic        no_shift = is_setup | (opc == AED_OP_UNUSED);
  wire logic [5:0]  count    = instr[5:0];
  wire logic        f_link   = ib(instr, AED_B_LINK);
  wire logic        f_clrq   = ib(instr, AED_B_CLRQ);
  wire logic        f_sign   = ib(instr, AED_B_SIGN);
  wire logic        f_orq    = ib(instr, AED_B_ORQ);
  wire logic        f_clrp   = ib(instr, AED_B_CLRP);
  wire logic        f_cmq    = ib(instr, AED_B_CMQ);
  wire logic        f_omq    = ib(instr, AED_B_OMQ);
  wire logic        f_osc    = ib(instr, AED_B_OSC);
  wire logic        ph_a     = busy & event_time[0];
  wire logic        ph_b     = busy & event_time[1];
  wire logic        ph_c     = busy & event_time[2];
  wire logic        ph_d     = busy & event_time[3];
  wire logic        ph_e     = busy & event_time[4];
  wire logic        ph_f     = busy & event_time[5];

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic paths

  // one add-and-shift-right multiply step, carry kept in bit 18
  wire logic [18:0] msum   = {1'b0, ac} + (mq[0] ? {1'b0, opnd} : 19'h00000);
  // one restoring divide step: trial subtract from {ac,mq} shifted left
  wire logic [18:0] dtrial = {ac, mq[17]} - {1'b0, opnd};
  wire logic        dfits  = ~dtrial[18];
  // signed: quotient msb would be set; unsigned: quotient needs a 19th bit
  wire logic        d_ovf  = f_sign ? dfits : (ac >= opnd);
  wire logic        n_stop = (ac[17] != ac[16]);
  wire logic        e_done = no_shift | (sc == AED_RST_STEP) |
                             (is_div & e_first & d_ovf) | (is_norm & n_stop);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: registered read data, no wait states

  wire logic        take   = hsel & htrans[1] & hready;
  wire logic        wr_idl = dph.wr & ~busy;
  wire logic        start  = wr_idl & (dph.ofs == AED_OFS_INSTR);
  wire logic [31:0] status = {25'h0000000, busy, event_time};
  wire logic [7:0]  rofs   = haddr[7:0];
  wire logic [31:0] rd_mux =
    (rofs == AED_OFS_INSTR)  ? {14'h0000, instr} :
    (rofs == AED_OFS_PRIM)   ? {14'h0000, ac} :
    (rofs == AED_OFS_QUOT)   ? {14'h0000, mq} :
    (rofs == AED_OFS_STEP)   ? {26'h0000000, sc} :
    (rofs == AED_OFS_LINK)   ? {31'h00000000, link} :
    (rofs == AED_OFS_OPND)   ? {14'h0000, opnd} :
    (rofs == AED_OFS_STATUS) ? status : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph       <= '0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dph       <= take ? {hwrite, ~hwrite, haddr[7:0]} : '0;
      hrdata    <= (take & ~hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and datapath

  always_comb begin
    next_state  = state;
    next_ev     = event_time;
    next_instr  = instr;
    next_ac     = ac;
    next_mq     = mq;
    next_opnd   = opnd;
    next_entry  = ac_entry;
    next_sc     = sc;
    next_link   = link;
    next_sign   = sign_flop;
    next_pneg   = prod_neg;
    next_efirst = e_first;
    if (!busy) begin
      if (wr_idl && dph.ofs == AED_OFS_PRIM) begin
        next_ac = hwdata[17:0];
      end
      if (wr_idl && dph.ofs == AED_OFS_QUOT) begin
        next_mq = hwdata[17:0];
      end
      if (wr_idl && dph.ofs == AED_OFS_STEP) begin
        next_sc = hwdata[5:0];
      end
      if (wr_idl && dph.ofs == AED_OFS_LINK) begin
        next_link = hwdata[0];
      end
      if (wr_idl && dph.ofs == AED_OFS_OPND) begin
        next_opnd = hwdata[17:0];
      end
      if (start) begin
        next_instr = hwdata[17:0];
        next_entry = ac;
        next_state = AED_RUN;
        next_ev    = AED_EV_A;
      end
    end else if (ph_a) begin
      // primary modifications use the entry value, sign taken first
      if (f_link) begin
        next_link = ac[17];
      end
      if (f_sign) begin
        next_sign = ac[17];
      end
      // cleared when unsigned, else a stale sign would complement this result
      next_pneg = f_sign & (ac[17] ^ link);
      if (f_clrp) begin
        next_ac = AED_RST_WORD;
      end else if (f_sign && !f_orq && ac[17]) begin
        next_ac = 18'(-ac);
      end
      next_ev = {event_time[4:0], 1'b0};
    end else if (ph_b) begin
      // or-in uses the primary value seen at instruction start
      next_mq = f_clrq ? AED_RST_WORD : mq;
      if (f_orq && !f_sign) begin
        next_mq = next_mq | ac_entry;
      end
      if (is_setup && f_cmq) begin
        next_mq = ~next_mq;
      end
      next_ev = {event_time[4:0], 1'b0};
    end else if (ph_c) begin
      if (is_setup) begin
        if (f_omq) begin
          next_ac = next_ac | mq;
        end
        if (f_osc) begin
          next_ac = next_ac | {12'h000, sc};
        end
      end else begin
        // counter runs up from minus the count and stops at zero
        next_sc = 6'(-count);
      end
      next_ev = {event_time[4:0], 1'b0};
    end else if (ph_d) begin
      next_efirst = 1'b1;
      if (is_setup) begin
        next_state = AED_IDLE;
        next_ev    = AED_RST_STEP;
      end else begin
        next_ev = {event_time[4:0], 1'b0};
      end
    end else if (ph_e) begin
      next_efirst = 1'b0;
      if (e_done) begin
        if (is_div && e_first && d_ovf) begin
          next_link = 1'b1;
        end
        next_ev = {event_time[4:0], 1'b0};
      end else begin
        next_sc = sc + 6'h01;
        case (opc)
          AED_OP_MUL: begin
            next_ac = msum[18:1];
            next_mq = {msum[0], mq[17:1]};
          end
          AED_OP_DIV: begin
            next_ac = dfits ? dtrial[17:0] : {ac[16:0], mq[17]};
            next_mq = {mq[16:0], dfits};
          end
          AED_OP_LRS: begin
            next_ac = {link, ac[17:1]};
            next_mq = {ac[0], mq[17:1]};
          end
          AED_OP_ALS: begin
            next_ac = {ac[16:0], link};
          end
          default: begin
            // long left and normalize share the path
            next_ac = {ac[16:0], mq[17]};
            next_mq = {mq[16:0], link};
          end
        endcase
      end
    end else if (ph_f) begin
      if ((is_mul || is_div) && prod_neg) begin
        next_mq = ~mq;
      end
      next_state = AED_IDLE;
      next_ev    = AED_RST_STEP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state      <= AED_IDLE;
      event_time <= AED_RST_STEP;
      instr      <= AED_RST_WORD;
      ac         <= AED_RST_WORD;
      mq         <= AED_RST_WORD;
      opnd       <= AED_RST_WORD;
      ac_entry   <= AED_RST_WORD;
      sc         <= AED_RST_STEP;
      link       <= 1'b0;
      sign_flop  <= 1'b0;
      prod_neg   <= 1'b0;
      e_first    <= 1'b0;
    end else begin
      state      <= next_state;
      event_time <= next_ev;
      instr      <= next_instr;
      ac         <= next_ac;
      mq         <= next_mq;
      opnd       <= next_opnd;
      ac_entry   <= next_entry;
      sc         <= next_sc;
      link       <= next_link;
      sign_flop  <= next_sign;
      prod_neg   <= next_pneg;
      e_first    <= next_efirst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_ring_onehot: assert property (
    busy |-> $onehot(event_time))
    else $error("event counter not one-hot while running");

  chk_setup_four: assert property (
    ph_a && is_setup |=> ##2 ph_d ##1 !busy)
    else $error("setup did not end after four phases");

  chk_long_six: assert property (
    ph_d && !is_setup |=> ph_e)
    else $error("non-setup skipped phase E");

  chk_primary_clear: assert property (
    ph_a && f_clrp |=> ac == AED_RST_WORD && event_time[1])
    else $error("primary not cleared in phase A");

  chk_link_sign: assert property (
    ph_a && f_link |=> link == $past(ac[17]))
    else $error("link did not take primary sign");

  chk_quot_phase: assert property (
    busy && $changed(mq) |-> $past(event_time[1] | event_time[4] | event_time[5]))
    else $error("quotient reg changed outside B, E or F");

  chk_step_load: assert property (
    ph_c && !is_setup |=> sc == 6'(-$past(count)))
    else $error("step counter not loaded from count");

  chk_div_ovf: assert property (
    ph_e && is_div && e_first && d_ovf |=> link && event_time[5])
    else $error("divide overflow not flagged in link");

  chk_shift_phase: assert property (
    busy && sc != $past(sc) && !$past(event_time[2]) |-> $past(event_time[4]))
    else $error("step taken outside phase E");

  chk_sign_capture: assert property (
    ph_a && f_sign |=> sign_flop == $past(ac[17]))
    else $error("sign flop did not capture primary sign");

  chk_pneg_unsigned: assert property (
    ph_a && !f_sign |=> !prod_neg)
    else $error("product sign left set for unsigned operation");

endmodule

// [rtl/aed_pkg.sv]
package aed_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] AED_OFS_INSTR  = 8'h00;
  localparam logic [7:0] AED_OFS_PRIM   = 8'h04;
  localparam logic [7:0] AED_OFS_QUOT   = 8'h08;
  localparam logic [7:0] AED_OFS_STEP   = 8'h0C;
  localparam logic [7:0] AED_OFS_LINK   = 8'h10;
  localparam logic [7:0] AED_OFS_OPND   = 8'h14;
  localparam logic [7:0] AED_OFS_STATUS = 8'h18;

  // instruction bit positions, bit 0 is the word's msb
  localparam int AED_B_LINK = 4;
  localparam int AED_B_CLRQ = 5;
  localparam int AED_B_SIGN = 6;
  localparam int AED_B_ORQ  = 7;
  localparam int AED_B_CLRP = 8;
  localparam int AED_B_CMQ  = 15;
  localparam int AED_B_OMQ  = 16;
  localparam int AED_B_OSC  = 17;

  // operation codes in bits 9..11
  localparam logic [2:0] AED_OP_SETUP  = 3'h0;
  localparam logic [2:0] AED_OP_MUL    = 3'h1;
  localparam logic [2:0] AED_OP_UNUSED = 3'h2;
  localparam logic [2:0] AED_OP_DIV    = 3'h3;
  localparam logic [2:0] AED_OP_NORM   = 3'h4;
  localparam logic [2:0] AED_OP_LRS    = 3'h5;
  localparam logic [2:0] AED_OP_LLS    = 3'h6;
  localparam logic [2:0] AED_OP_ALS    = 3'h7;

  // reset values, and the phase-A event value loaded at instruction start
  localparam logic [17:0] AED_RST_WORD = 18'h00000;
  localparam logic [5:0]  AED_RST_STEP = 6'h00;
  localparam logic [5:0]  AED_EV_A     = 6'h01;

  typedef enum logic {AED_IDLE, AED_RUN} aed_state_t;

  // data-phase record of an accepted bus transfer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] ofs;
  } aed_ahb_t;

endpackage

// [tb/aed_host.sv]
`timescale 1ns/1ps
// host core model: issues single word transfers as an ahb-lite master
module aed_host
  import aed_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             timed_out
);
  initial begin
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hsize     = 3'h2;
    hwdata    = 32'h0;
    timed_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // bounded wait: a stuck slave must not hang the run
  task automatic edge_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (hreadyout !== 1'b1) timed_out <= 1'b1;
  endtask

  // called just after a rising edge; returns at the edge ending the data phase
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rdv);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    edge_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    // on reads the data lines carry junk, never a stale copy
    hwdata <= wr ? wd : ~hwdata;
    edge_ready();
    rdv = hrdata;
  endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench
  import aed_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        timed_out;
  int          fail_count = 0;
  int          tests_run = 0;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  aed_core u_aed_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
  );

  aed_host u_aed_host (
    .hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .timed_out(timed_out)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // a bus wait that ran out ends the run at once
  always @(posedge timed_out) begin
    check({31'h0, timed_out}, 32'h0);
    end_sim();
  end

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] unused;
    u_aed_host.xfer(1'b1, ofs, d, unused);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] v;
    u_aed_host.xfer(1'b0, ofs, 32'h0, v);
    check(v, exp);
  endtask

  // polls busy; a run that never ends counts as a mismatch
  task automatic wait_idle;
    logic [31:0] v;
    int          n;
    v = 32'h40;
    for (n = 0; n < 200 && v[6] !== 1'b0; n++) u_aed_host.xfer(1'b0, AED_OFS_STATUS, 32'h0, v);
    if (v[6] !== 1'b0) begin
      check(v, 32'h0);
      end_sim();
    end
  endtask

  task automatic load(input logic [17:0] p, input logic [17:0] q, input logic l);
    wr(AED_OFS_PRIM, {14'h0, p});
    wr(AED_OFS_QUOT, {14'h0, q});
    wr(AED_OFS_LINK, {31'h0, l});
  endtask

  // words are msb-first numbered: instruction bit n is word[17-n]
  task automatic op_case(input logic [17:0] w, input logic [17:0] p, input logic [17:0] q,
                         input logic l, input logic [17:0] ep, input logic [17:0] eq,
                         input logic el);
    load(p, q, l);
    wr(AED_OFS_INSTR, {14'h0, w});
    wait_idle();
    rd_chk(AED_OFS_PRIM, {14'h0, ep});
    rd_chk(AED_OFS_QUOT, {14'h0, eq});
    rd_chk(AED_OFS_LINK, {31'h0, el});
  endtask

  task automatic div_case(input logic [17:0] w, input logic [17:0] p, input logic [17:0] q,
                          input logic [17:0] d, input logic el);
    wr(AED_OFS_OPND, {14'h0, d});
    load(p, q, 1'b0);
    wr(AED_OFS_INSTR, {14'h0, w});
    wait_idle();
    rd_chk(AED_OFS_LINK, {31'h0, el});
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk(AED_OFS_PRIM, 32'h0);
    rd_chk(AED_OFS_STEP, 32'h0);
    rd_chk(AED_OFS_STATUS, 32'h0);
    wr(8'h40, 32'h1);
    rd_chk(8'h40, 32'h0);
    check({31'h0, hresp}, 32'h0);
  endtask

  // status sampled every second cycle: setup ends after d, others after f
  task automatic t_phases;
    load(18'h00155, 18'h0, 1'b0);
    wr(AED_OFS_INSTR, 32'h34000);
    rd_chk(AED_OFS_STATUS, 32'h41);
    rd_chk(AED_OFS_STATUS, 32'h44);
    rd_chk(AED_OFS_STATUS, 32'h0);
    rd_chk(AED_OFS_PRIM, 32'h155);
    wr(AED_OFS_INSTR, 32'h34140);
    rd_chk(AED_OFS_STATUS, 32'h41);
    rd_chk(AED_OFS_STATUS, 32'h44);
    rd_chk(AED_OFS_STATUS, 32'h50);
    rd_chk(AED_OFS_STATUS, 32'h0);
  endtask

  // the write to primary lands while busy and must be dropped
  task automatic t_norm;
    load(18'h0, 18'h3, 1'b0);
    wr(AED_OFS_INSTR, 32'h34124);
    wr(AED_OFS_PRIM, 32'h3FFFF);
    wait_idle();
    rd_chk(AED_OFS_PRIM, 32'h18000);
    rd_chk(AED_OFS_QUOT, 32'h0);
    rd_chk(AED_OFS_STEP, 32'h3D);
  endtask

  task automatic t_ops;
    op_case(18'h34201, 18'h2AAAA, 18'h0, 0, 18'h3D, 18'h0, 0);
    op_case(18'h34001, 18'h100, 18'h0, 0, 18'h13D, 18'h0, 0);
    op_case(18'h34002, 18'h100, 18'hF, 0, 18'h10F, 18'hF, 0);
    op_case(18'h34004, 18'h0, 18'h0F0F0, 0, 18'h0, 18'h30F0F, 0);
    op_case(18'h34202, 18'h1, 18'h155, 0, 18'h155, 18'h155, 0);
    op_case(18'h35000, 18'h7, 18'h3FFFF, 0, 18'h7, 18'h0, 0);
    op_case(18'h35400, 18'h123, 18'h3, 0, 18'h123, 18'h123, 0);
    op_case(18'h36800, 18'h3FFFB, 18'h0, 0, 18'h5, 18'h0, 1);
    op_case(18'h34800, 18'h3FFFE, 18'h0, 0, 18'h2, 18'h0, 0);
    op_case(18'h34080, 18'h5, 18'h9, 0, 18'h5, 18'h9, 0);
    op_case(18'h34143, 18'h5, 18'h0, 0, 18'h0, 18'h28000, 0);
    op_case(18'h36141, 18'h20000, 18'h0, 0, 18'h30000, 18'h0, 1);
    op_case(18'h34183, 18'h0, 18'h20001, 0, 18'h4, 18'h8, 0);
    op_case(18'h341C3, 18'h1, 18'h8, 0, 18'h8, 18'h8, 0);
    wr(AED_OFS_OPND, 32'h2);
    op_case(18'h35652, 18'h5, 18'h0, 0, 18'h0, 18'hA, 0);
    op_case(18'h35E52, 18'h20000, 18'h0, 0, 18'h0, 18'h3FFFF, 0);
  endtask

  // overflow limits probed at their exact boundary
  task automatic t_div;
    div_case(18'h340D3, 18'h5, 18'h0, 18'h5, 1);
    div_case(18'h340D3, 18'h4, 18'h0, 18'h5, 0);
    div_case(18'h348D3, 18'h2, 18'h20000, 18'h5, 1);
    div_case(18'h348D3, 18'h2, 18'h0, 18'h5, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_phases();
    t_norm();
    t_ops();
    t_div();
    check({31'h0, timed_out}, 32'h0);
    end_sim();
  end
endmodule
